/* File: rtl/dma_pkg.sv */
// constants, carriers and register layout of the tag-chaining dma slave
package dma_pkg;
  // tag table geometry, one 8-byte entry per index
  localparam int TAG_IDX_W = 12;
  localparam int TAG_ENTRIES = 4096;
  localparam int TAG_RAM_AW = 13;
  localparam logic [23:0] TAG_TABLE_BASE = 24'h800000;
  localparam logic [23:0] TAG_TABLE_LAST = 24'h807FFF;
  localparam logic [11:0] END_OF_CHAIN = 12'hFFF;
  // channel register window
  localparam logic [15:0] CHAN_PAGE = 16'h0001;
  localparam logic [1:0] REG_CTL = 2'h0;
  localparam logic [1:0] REG_ADDR = 2'h1;
  localparam int CHANNELS = 16;
  localparam logic [3:0] PROC_LEVEL = 4'hF;
  // control word fields; msb-first bit 0 lands on bit 31
  localparam int ST_HI = 31;
  localparam int ST_LO = 28;
  localparam int KEEP_LO = 27;
  localparam int F_SLAVE = 27;
  localparam int F_SYSMEM = 26;
  localparam int F_CNT_PULSE = 25;
  localparam int F_DIR = 24;
  localparam int NEXT_HI = 23;
  localparam int NEXT_LO = 12;
  localparam int CNT_HI = 11;
  localparam int CNT_LO = 0;
  localparam logic [3:0] ST_DISABLED = 4'h0;
  localparam logic [3:0] ST_ENABLED = 4'h1;
  localparam logic [3:0] ERR_INVALID_OP = 4'h8;
  localparam logic [3:0] ERR_XFER = 4'hC;
  localparam logic [31:0] REG_RESET = 32'h0;
  // per-channel data buffer
  localparam int BUF_BYTES = 64;
  localparam int BUF_AW = 8;
  localparam logic [3:0] BUF_LAST = 4'hF;
  localparam logic [2:0] BYTE_N = 3'h1;
  localparam logic [2:0] WORD_N = 3'h4;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_CPURD = 4'h1, S_ISSUE = 4'h2, S_FILL = 4'h3,
    S_BUFRD = 4'h4, S_MEMRD = 4'h5, S_MEMWR = 4'h6, S_FLRD = 4'h7,
    S_FLUSH = 4'h8, S_STEP = 4'h9, S_TAG0 = 4'hA, S_TAG4 = 4'hB,
    S_TAGLD = 4'hC
  } state_type;
  typedef struct packed {
    logic valid;
    logic we;
    logic key;
    logic [1:0] size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } cpu_req_type;
  typedef struct packed {
    logic valid;
    logic [3:0] level;
    logic wide;
    logic [31:0] wdata;
  } io_req_type;
  typedef struct packed {
    logic req;
    logic we;
    logic sys;
    logic [3:0] be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_type;
endpackage

/* File: rtl/tag_table_ram.sv */
// tag table storage, two words per entry, registered read
`timescale 1ns/1ps
module tag_table_ram (
  input wire logic clk,
  input wire logic [dma_pkg::TAG_RAM_AW-1:0] addr,
  input wire logic we,
  input wire logic [31:0] wdata,
  output logic [31:0] q
);
  logic [31:0] mem [2*dma_pkg::TAG_ENTRIES];
  // single port, read-before-write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    q <= mem[addr];
  end
endmodule

/* File: rtl/chan_buf_ram.sv */
// per-channel data buffers with byte lanes, registered read
`timescale 1ns/1ps
module chan_buf_ram (
  input wire logic clk,
  input wire logic [dma_pkg::BUF_AW-1:0] addr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  output logic [31:0] q
);
  logic [31:0] mem [dma_pkg::CHANNELS*dma_pkg::BUF_BYTES/4];
  // byte lanes in one writer; separate lane processes would all drive the same array
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        mem[addr][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
  end
  // read port
  always_ff @(posedge clk) begin
    q <= mem[addr];
  end
endmodule

/* File: rtl/dma_tag_chain.sv */
// tag-chaining dma slave controller with tag table and channel registers
`timescale 1ns/1ps
// Behaviour
// - tag memory holds 4096 entries addressed by a 12-bit index
// - count expiry or page crossing fetches next tag and reloads channel registers
// - software stores first tag into registers 0 and 4; they mirror the tag
// - buffered mode: 64-byte buffer per channel, system memory device cycles use only it
// - unbuffered narrow device writes to system memory use read-modify-write
// - bus memory transfers never use the channel buffers
// - tag table decoded at 0x800000 to 0x807FFF
// - key 1 access refused, storage interrupt, invalid-op status in channel 15
// - tag memory takes only full word accesses
// - tag bits 0-4 are zero and never copied into the status bits
// - bit 5 picks system memory (1) or bus memory (0)
// - bit 6 set pulses terminal count at each count expiry; chaining continues
// - count expiry with next index 0xFFF always pulses terminal count
// - bit 7 zero moves memory to device, one moves device to memory
// - bits 8-19 index the tag loaded when the count expires
// - expiry with next index all ones disables channel, later requests refused
// - bits 20-31 hold byte count minus one, within the page
// - register 4 holds the 32-bit real address
// - address bits 28 and 29 select the word of a channel register set
// - sixteen channel status registers, one per arbitration level
// - transfer error records code, freezes registers, refuses requests until store
module dma_tag_chain (
  input wire logic clk,
  input wire logic rst,
  input wire logic buffered_mode,
  input wire dma_pkg::cpu_req_type cpu,
  output logic cpu_ack,
  output logic [31:0] cpu_rdata,
  output logic cpu_dsi,
  input wire dma_pkg::io_req_type io,
  output logic io_ack,
  output logic io_refused,
  output logic [31:0] io_rdata,
  output logic terminal_count_pulse,
  output dma_pkg::mem_cmd_type mem_cmd,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata
);
  dma_pkg::state_type state;
  logic [31:0] channel_state_reg [dma_pkg::CHANNELS];
  logic [31:0] tag_real_address_word [dma_pkg::CHANNELS];
  logic [15:0] buf_valid;
  logic [3:0] ch;
  logic [3:0] cnt4;
  logic [31:0] hold;
  logic wide_q;
  logic [31:0] io_wdata_q;
  logic [31:0] tag_word0;
  logic [12:0] tag_addr;
  logic tag_we;
  logic [31:0] tag_q;
  logic [7:0] buf_addr;
  logic [3:0] buf_be;
  logic [31:0] buf_wdata;
  logic [31:0] buf_q;

  // usable: enabled, no error code, slave flag set
  function automatic logic chan_usable(input logic [31:0] c);
    return c[dma_pkg::ST_HI:dma_pkg::ST_LO] == dma_pkg::ST_ENABLED && c[dma_pkg::F_SLAVE];
  endfunction

  function automatic logic [3:0] lane_be(input logic [1:0] lane, input logic wide);
    return wide ? 4'hF : 4'(4'h1 << lane);
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] lane_pick(input logic [31:0] w, input logic [1:0] lane,
                                            input logic wide);
    return wide ? w : {24'h0, w[8*lane +: 8]};
  endfunction

  // base plus index times eight; base is 32k aligned so it drops out
  function automatic logic [12:0] tag_index(input logic [11:0] idx, input logic word4);
    logic [14:0] ofs;
    ofs = {idx, 3'h0} | {12'h0, word4, 2'h0};
    return ofs[14:2];
  endfunction

  // active channel view
  wire [31:0] cur_ctl = channel_state_reg[ch];
  wire [31:0] cur_adr = tag_real_address_word[ch];
  wire [11:0] cur_next = cur_ctl[dma_pkg::NEXT_HI:dma_pkg::NEXT_LO];
  wire [11:0] cur_cnt = cur_ctl[dma_pkg::CNT_HI:dma_pkg::CNT_LO];
  wire [2:0] nbytes = wide_q ? dma_pkg::WORD_N : dma_pkg::BYTE_N;
  wire [12:0] cnt_plus = {1'b0, cur_cnt} + 13'h1;
  wire expire = cnt_plus <= {10'h0, nbytes};
  wire [31:0] adr_next = cur_adr + {29'h0, nbytes};
  wire page_cross = adr_next[11:0] == 12'h0;
  wire line_cross = adr_next[5:0] == 6'h0;
  wire to_dev = !cur_ctl[dma_pkg::F_DIR];
  wire sysmem = cur_ctl[dma_pkg::F_SYSMEM];
  wire use_buf = buffered_mode && sysmem;
  wire rmw = sysmem && !wide_q && !to_dev;
  wire reload = expire || page_cross;
  wire chain_end = reload && cur_next == dma_pkg::END_OF_CHAIN;
  wire pulse = expire && (cur_ctl[dma_pkg::F_CNT_PULSE] || cur_next == dma_pkg::END_OF_CHAIN);

  // request decode, one request at a time from idle
  wire cpu_go = state == dma_pkg::S_IDLE && cpu.valid && !cpu_ack;
  wire io_go = state == dma_pkg::S_IDLE && !cpu_go && io.valid && !io_ack;
  wire in_tag = cpu.addr >= dma_pkg::TAG_TABLE_BASE && cpu.addr <= dma_pkg::TAG_TABLE_LAST;
  wire in_chan = cpu.addr[23:8] == dma_pkg::CHAN_PAGE;
  wire priv_fault = cpu_go && (in_tag || in_chan) && cpu.key;
  wire word_ok = cpu.size == dma_pkg::SIZE_WORD;
  wire cpu_ok = cpu_go && !cpu.key && word_ok;
  wire tag_rd = cpu_ok && in_tag && !cpu.we;
  wire chan_wr = cpu_ok && in_chan && cpu.we;
  wire [1:0] wsel = cpu.addr[3:2];
  wire [3:0] cw_ch = cpu.addr[7:4];
  wire io_ch_ok = io.level != dma_pkg::PROC_LEVEL && chan_usable(channel_state_reg[io.level]);
  wire mem_wait = state == dma_pkg::S_FILL || state == dma_pkg::S_MEMRD ||
                  state == dma_pkg::S_MEMWR || state == dma_pkg::S_FLUSH;
  wire xfer_err = mem_wait && mem_ack && mem_err;

  // tag table port: processor in idle, chain fetch otherwise
  always_comb begin
    tag_addr = cpu.addr[14:2];
    tag_we = cpu_ok && in_tag && cpu.we;
    if (state == dma_pkg::S_TAG0) begin
      tag_addr = tag_index(cur_next, 1'b0);
    end else if (state == dma_pkg::S_TAG4) begin
      tag_addr = tag_index(cur_next, 1'b1);
    end
  end

  tag_table_ram u_tag (
    .clk(clk),
    .addr(tag_addr),
    .we(tag_we),
    .wdata(cpu.wdata),
    .q(tag_q)
  );

  // buffer port: line fill and flush walk the words, else current word
  always_comb begin
    buf_addr = {ch, cur_adr[5:2]};
    buf_be = 4'h0;
    buf_wdata = wide_q ? io_wdata_q : {4{io_wdata_q[7:0]}};
    if (state == dma_pkg::S_FILL) begin
      buf_addr = {ch, cnt4};
      buf_be = (mem_ack && !mem_err) ? 4'hF : 4'h0;
      buf_wdata = mem_rdata;
    end else if (state == dma_pkg::S_BUFRD && !to_dev) begin
      // pre-read of the first flush word, so its data stands when the write issues
      buf_addr = {ch, cnt4};
    end else if (state == dma_pkg::S_FLUSH) begin
      // read one word ahead while the memory answers
      buf_addr = {ch, 4'(cnt4 + 4'h1)};
    end else if (state == dma_pkg::S_ISSUE && use_buf && !to_dev) begin
      buf_be = lane_be(cur_adr[1:0], wide_q);
    end
  end

  chan_buf_ram u_buf (
    .clk(clk),
    .addr(buf_addr),
    .be(buf_be),
    .wdata(buf_wdata),
    .q(buf_q)
  );

  // sequencer and memory command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= dma_pkg::S_IDLE;
      ch <= 4'h0;
      cnt4 <= 4'h0;
      hold <= 32'h0;
      wide_q <= 1'b0;
      io_wdata_q <= 32'h0;
      tag_word0 <= 32'h0;
      mem_cmd <= '0;
    end else if (xfer_err) begin
      state <= dma_pkg::S_IDLE;
      mem_cmd.req <= 1'b0;
    end else begin
      case (state)
        dma_pkg::S_IDLE: begin
          if (tag_rd) begin
            state <= dma_pkg::S_CPURD;
          end else if (io_go && io_ch_ok) begin
            ch <= io.level;
            wide_q <= io.wide;
            io_wdata_q <= io.wdata;
            state <= dma_pkg::S_ISSUE;
          end
        end
        dma_pkg::S_ISSUE: begin
          cnt4 <= 4'h0;
          if (use_buf && to_dev) begin
            if (buf_valid[ch]) begin
              state <= dma_pkg::S_BUFRD;
            end else begin
              mem_cmd <= '{1'b1, 1'b0, 1'b1, 4'hF, {cur_adr[31:6], 6'h0}, 32'h0};
              state <= dma_pkg::S_FILL;
            end
          end else if (use_buf) begin
            // written into buffer this cycle; flush at line end or expiry, after a pre-read
            state <= (line_cross || expire) ? dma_pkg::S_BUFRD : dma_pkg::S_STEP;
          end else if (to_dev || rmw) begin
            mem_cmd <= '{1'b1, 1'b0, sysmem, sysmem ? 4'hF : lane_be(cur_adr[1:0], wide_q),
                         sysmem ? {cur_adr[31:2], 2'h0} : cur_adr, 32'h0};
            state <= dma_pkg::S_MEMRD;
          end else begin
            mem_cmd <= '{1'b1, 1'b1, sysmem, lane_be(cur_adr[1:0], wide_q),
                         sysmem ? {cur_adr[31:2], 2'h0} : cur_adr, buf_wdata};
            state <= dma_pkg::S_MEMWR;
          end
        end
        dma_pkg::S_FILL: begin
          if (mem_ack) begin
            cnt4 <= cnt4 + 4'h1;
            mem_cmd.addr <= {cur_adr[31:6], cnt4 + 4'h1, 2'h0};
            if (cnt4 == dma_pkg::BUF_LAST) begin
              mem_cmd.req <= 1'b0;
              state <= dma_pkg::S_BUFRD;
            end
          end
        end
        dma_pkg::S_BUFRD: begin
          state <= to_dev ? dma_pkg::S_STEP : dma_pkg::S_FLRD;
        end
        dma_pkg::S_MEMRD: begin
          if (mem_ack) begin
            hold <= mem_rdata;
            if (to_dev) begin
              mem_cmd.req <= 1'b0;
              state <= dma_pkg::S_STEP;
            end else begin
              // merge the narrow byte into the word just read
              mem_cmd.we <= 1'b1;
              mem_cmd.wdata <= lane_merge(mem_rdata, buf_wdata, lane_be(cur_adr[1:0], 1'b0));
              state <= dma_pkg::S_MEMWR;
            end
          end
        end
        dma_pkg::S_MEMWR: begin
          if (mem_ack) begin
            mem_cmd.req <= 1'b0;
            state <= dma_pkg::S_STEP;
          end
        end
        dma_pkg::S_FLRD: begin
          state <= dma_pkg::S_FLUSH;
          mem_cmd <= '{1'b1, 1'b1, 1'b1, 4'hF, {cur_adr[31:6], cnt4, 2'h0}, buf_q};
        end
        dma_pkg::S_FLUSH: begin
          if (mem_ack) begin
            mem_cmd.req <= 1'b0;
            cnt4 <= cnt4 + 4'h1;
            state <= (cnt4 == dma_pkg::BUF_LAST) ? dma_pkg::S_STEP : dma_pkg::S_FLRD;
          end
        end
        dma_pkg::S_STEP: begin
          state <= (reload && !chain_end) ? dma_pkg::S_TAG0 : dma_pkg::S_IDLE;
        end
        dma_pkg::S_TAG0: begin
          state <= dma_pkg::S_TAG4;
        end
        dma_pkg::S_TAG4: begin
          tag_word0 <= tag_q;
          state <= dma_pkg::S_TAGLD;
        end
        default: begin
          state <= dma_pkg::S_IDLE;
        end
      endcase
    end
  end

  // channel register sets, one per arbitration level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < dma_pkg::CHANNELS; i++) begin
        channel_state_reg[i] <= dma_pkg::REG_RESET;
        tag_real_address_word[i] <= dma_pkg::REG_RESET;
      end
      buf_valid <= 16'h0;
    end else if (chan_wr) begin
      // a store loads the first tag; a store to register 0 also clears a recorded error
      if (wsel == dma_pkg::REG_CTL) begin
        channel_state_reg[cw_ch] <= cpu.wdata;
      end else if (wsel == dma_pkg::REG_ADDR) begin
        tag_real_address_word[cw_ch] <= cpu.wdata;
      end
      buf_valid[cw_ch] <= 1'b0;
    end else if (priv_fault) begin
      channel_state_reg[dma_pkg::PROC_LEVEL][dma_pkg::ST_HI:dma_pkg::ST_LO] <=
        dma_pkg::ERR_INVALID_OP;
    end else if (xfer_err) begin
      // count and address stay frozen at the failing transfer
      channel_state_reg[ch][dma_pkg::ST_HI:dma_pkg::ST_LO] <= dma_pkg::ERR_XFER;
    end else if (state == dma_pkg::S_FILL && mem_ack && cnt4 == dma_pkg::BUF_LAST) begin
      buf_valid[ch] <= 1'b1;
    end else if (state == dma_pkg::S_STEP) begin
      if (chain_end) begin
        channel_state_reg[ch][dma_pkg::ST_HI:dma_pkg::ST_LO] <= dma_pkg::ST_DISABLED;
      end else if (!reload) begin
        channel_state_reg[ch][dma_pkg::CNT_HI:dma_pkg::CNT_LO] <= cur_cnt - {9'h0, nbytes};
        tag_real_address_word[ch] <= adr_next;
      end
      if (line_cross || reload) begin
        buf_valid[ch] <= 1'b0;
      end
    end else if (state == dma_pkg::S_TAGLD) begin
      // status and slave flag are never taken from the tag
      channel_state_reg[ch] <= {cur_ctl[31:dma_pkg::KEEP_LO],
                                tag_word0[dma_pkg::KEEP_LO-1:0]};
      tag_real_address_word[ch] <= tag_q;
      buf_valid[ch] <= 1'b0;
    end
  end

  // answers to processor and device
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_ack <= 1'b0;
      cpu_dsi <= 1'b0;
      cpu_rdata <= 32'h0;
      io_ack <= 1'b0;
      io_refused <= 1'b0;
      io_rdata <= 32'h0;
      terminal_count_pulse <= 1'b0;
    end else begin
      cpu_ack <= (cpu_go && !tag_rd) || state == dma_pkg::S_CPURD;
      cpu_dsi <= priv_fault;
      io_ack <= (io_go && !io_ch_ok) || xfer_err || state == dma_pkg::S_STEP;
      io_refused <= (io_go && !io_ch_ok) || xfer_err;
      terminal_count_pulse <= state == dma_pkg::S_STEP && pulse;
      if (state == dma_pkg::S_CPURD) begin
        cpu_rdata <= tag_q;
      end else if (cpu_go) begin
        cpu_rdata <= 32'h0;
        if (cpu_ok && in_chan && wsel == dma_pkg::REG_CTL) begin
          cpu_rdata <= channel_state_reg[cw_ch];
        end else if (cpu_ok && in_chan && wsel == dma_pkg::REG_ADDR) begin
          cpu_rdata <= tag_real_address_word[cw_ch];
        end
      end
      if (state == dma_pkg::S_STEP && to_dev) begin
        io_rdata <= lane_pick(use_buf ? buf_q : hold, cur_adr[1:0], wide_q);
      end
    end
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  priv_refuse_a: assert property (priv_fault |=> cpu_ack && cpu_dsi)
    else $error("privileged access not refused");
  tag_range_a: assert property (tag_we |-> in_tag && !cpu.key)
    else $error("tag write outside table or with key one");
  word_only_a: assert property (tag_we |-> cpu.size == dma_pkg::SIZE_WORD)
    else $error("narrow tag write accepted");
  chain_stop_a: assert property (state == dma_pkg::S_STEP && chain_end |=>
    state == dma_pkg::S_IDLE && channel_state_reg[ch][dma_pkg::ST_HI:dma_pkg::ST_LO] == dma_pkg::ST_DISABLED)
    else $error("channel not disabled at chain end");
  end_pulse_a: assert property (state == dma_pkg::S_STEP && expire &&
    cur_next == dma_pkg::END_OF_CHAIN |=> terminal_count_pulse)
    else $error("no terminal count at chain end");
  count_pulse_a: assert property (terminal_count_pulse |-> $past(state) == dma_pkg::S_STEP)
    else $error("terminal count outside a step");
  reload_seq_a: assert property (state == dma_pkg::S_STEP && reload && !chain_end |=>
    state == dma_pkg::S_TAG0 ##2 state == dma_pkg::S_TAGLD)
    else $error("tag reload sequence broken");
  addr_load_a: assert property (state == dma_pkg::S_TAGLD |=> tag_real_address_word[ch] == $past(tag_q))
    else $error("address word not reloaded");
  no_bus_buf_a: assert property (state == dma_pkg::S_FILL || state == dma_pkg::S_FLUSH |->
    mem_cmd.sys)
    else $error("buffer traffic toward bus memory");
  rmw_write_a: assert property (state == dma_pkg::S_MEMRD && mem_ack && !mem_err && rmw |=>
    state == dma_pkg::S_MEMWR && mem_cmd.we && mem_cmd.be == 4'hF)
    else $error("narrow write skipped merge");
  err_freeze_a: assert property (xfer_err |=> io_refused &&
    channel_state_reg[ch][dma_pkg::ST_HI:dma_pkg::ST_LO] == dma_pkg::ERR_XFER)
    else $error("transfer error not recorded");
  cover_reload_c: cover property (state == dma_pkg::S_TAGLD);
  cover_fill_c: cover property (state == dma_pkg::S_FILL && mem_ack && cnt4 == dma_pkg::BUF_LAST);
  cover_rmw_c: cover property (state == dma_pkg::S_MEMRD && rmw ##1 state == dma_pkg::S_MEMWR);
  cover_priv_c: cover property (priv_fault);
endmodule

/* File: sim/mem_model.sv */
// memory partner that answers the dma block's memory port after a short wait
`timescale 1ns/1ps
module mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire dma_pkg::mem_cmd_type cmd,
  input wire logic fail,
  output logic ack,
  output logic err,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:255];
  logic [1:0] wait_cnt;
  dma_pkg::mem_cmd_type last;
  // two idle cycles before each answer, so the block never sees an instant memory
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      err <= 1'b0;
      wait_cnt <= 2'h0;
      rdata <= 32'h0;
    end else begin
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= ~rdata; // data not held once answered
      if (cmd.req && !ack) begin
        if (wait_cnt == 2'h2) begin
          ack <= 1'b1;
          err <= fail;
          rdata <= mem[cmd.addr[9:2]];
          last <= cmd;
          wait_cnt <= 2'h0;
          for (int i = 0; i < 4; i++) begin
            if (cmd.we && cmd.be[i]) mem[cmd.addr[9:2]][8*i +: 8] <= cmd.wdata[8*i +: 8];
          end
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the tag-chaining dma slave
`timescale 1ns/1ps
module testbench;
  logic clk, rst, buffered_mode, cpu_ack, cpu_dsi, io_ack, io_refused, terminal_count_pulse;
  logic mem_ack, mem_err, fail, dsi, refd, cnt_pulse;
  logic [31:0] cpu_rdata, io_rdata, mem_rdata, rd, iord;
  dma_pkg::cpu_req_type cpu;
  dma_pkg::io_req_type io;
  dma_pkg::mem_cmd_type mem_cmd;
  int n_errors, n_tests;
  dma_tag_chain dma_tag_chain_inst (.clk(clk), .rst(rst), .buffered_mode(buffered_mode), .cpu(cpu),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .cpu_dsi(cpu_dsi), .io(io), .io_ack(io_ack),
    .io_refused(io_refused), .io_rdata(io_rdata), .terminal_count_pulse(terminal_count_pulse),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata));
  mem_model mem_model_inst (.clk(clk), .rst(rst), .cmd(mem_cmd), .fail(fail), .ack(mem_ack),
    .err(mem_err), .rdata(mem_rdata));
  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // processor load or store, held until the acknowledge is seen
  task automatic cpu_op(input logic we, input logic key, input logic [1:0] size, input logic [23:0] a,
                        input logic [31:0] d);
    int i;
    @(negedge clk);
    cpu = '{1'b1, we, key, size, a, d};
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if (cpu_ack === 1'b1) break;
    end
    if (i == 300) begin
      n_errors++;
      final_report();
    end
    rd = cpu_rdata;
    dsi = cpu_dsi;
    @(negedge clk);
    cpu.valid = 1'b0;
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    cpu_op(1'b1, 1'b0, dma_pkg::SIZE_WORD, a, d);
  endtask
  task automatic rd_chk(input string name, input logic [23:0] a, input logic [31:0] exp);
    cpu_op(1'b0, 1'b0, dma_pkg::SIZE_WORD, a, 32'h0);
    check(name, rd, exp);
  endtask
  // device byte request on one arbitration level
  task automatic io_op(input logic [3:0] lvl, input logic [31:0] d);
    int i;
    @(negedge clk);
    io = '{1'b1, lvl, 1'b0, d};
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if (io_ack === 1'b1) break;
    end
    if (i == 300) begin
      n_errors++;
      final_report();
    end
    iord = io_rdata;
    refd = io_refused;
    cnt_pulse = terminal_count_pulse;
    @(negedge clk);
    io.valid = 1'b0;
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    buffered_mode = 1'b0;
    fail = 1'b0;
    cpu = '0;
    io = '0;
    n_errors = 0;
    n_tests = 0;
    mem_model_inst.mem[8] = 32'h44332211;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd_chk("chan0 ctl", 24'h000100, 32'h0);
    $display("test reset done");
    wr(24'h800018, 32'h00FFF001);
    wr(24'h80001C, 32'h00000020);
    rd_chk("tag3 word0", 24'h800018, 32'h00FFF001);
    rd_chk("tag3 word4", 24'h80001C, 32'h00000020);
    wr(24'h807FF4, 32'h5A5A0001);
    rd_chk("top entry", 24'h807FF4, 32'h5A5A0001);
    rd_chk("unmapped", 24'h808000, 32'h0);
    cpu_op(1'b1, 1'b0, 2'h1, 24'h800018, 32'hFFFFFFFF);
    rd_chk("halfword store", 24'h800018, 32'h00FFF001);
    cpu_op(1'b1, 1'b1, dma_pkg::SIZE_WORD, 24'h800018, 32'h0);
    check("key1 dsi", {31'h0, dsi}, 32'h1);
    rd_chk("key1 no effect", 24'h800018, 32'h00FFF001);
    cpu_op(1'b0, 1'b0, dma_pkg::SIZE_WORD, 24'h0001F0, 32'h0);
    check("chan15 status", {28'h0, rd[31:28]}, 32'h8);
    $display("test table done");
    wr(24'h000114, 32'h00000010);
    wr(24'h000110, 32'h1B003000);
    io_op(4'h1, 32'h000000A5);
    check("first refused", {31'h0, refd}, 32'h0);
    check("pulse enabled", {31'h0, cnt_pulse}, 32'h1);
    check("bus mem byte", {24'h0, mem_model_inst.mem[4][7:0]}, 32'hA5);
    check("bus target", {31'h0, mem_model_inst.last.sys}, 32'h0);
    rd_chk("reloaded ctl", 24'h000110, 32'h18FFF001);
    rd_chk("reloaded addr", 24'h000114, 32'h00000020);
    io_op(4'h1, 32'h0);
    check("read byte0", {24'h0, iord[7:0]}, 32'h11);
    check("mid pulse", {31'h0, cnt_pulse}, 32'h0);
    check("read dir", {31'h0, mem_model_inst.last.we}, 32'h0);
    io_op(4'h1, 32'h0);
    check("read byte1", {24'h0, iord[7:0]}, 32'h22);
    check("chain end pulse", {31'h0, cnt_pulse}, 32'h1);
    io_op(4'h1, 32'h0);
    check("after end", {31'h0, refd}, 32'h1);
    $display("test chain done");
    io_op(4'hF, 32'h0);
    check("level15", {31'h0, refd}, 32'h1);
    wr(24'h000124, 32'h00000030);
    wr(24'h000120, 32'h19000000);
    fail = 1'b1;
    io_op(4'h2, 32'h0);
    fail = 1'b0;
    check("mem error", {31'h0, refd}, 32'h1);
    cpu_op(1'b0, 1'b0, dma_pkg::SIZE_WORD, 24'h000120, 32'h0);
    check("error code", {28'h0, rd[31:28]}, 32'hC);
    io_op(4'h2, 32'h0);
    check("frozen", {31'h0, refd}, 32'h1);
    $display("test error done");
    // narrow device write to system memory, unbuffered
    mem_model_inst.mem[8'h11] = 32'hDDCCBBAA;
    wr(24'h000134, 32'h00000045);
    wr(24'h000130, 32'h1DFFF000);
    io_op(4'h3, 32'h0000005E);
    check("merged word", mem_model_inst.mem[8'h11], 32'hDDCC5EAA);
    check("merge write be", {28'h0, mem_model_inst.last.be}, 32'hF);
    check("sys target", {31'h0, mem_model_inst.last.sys}, 32'h1);
    check("merge end pulse", {31'h0, cnt_pulse}, 32'h1);
    $display("test merge done");
    // buffered memory-to-device: line fill, then a buffer hit
    mem_model_inst.mem[8'h20] = 32'h87654321;
    buffered_mode = 1'b1;
    wr(24'h000144, 32'h00000080);
    wr(24'h000140, 32'h1CFFF001);
    io_op(4'h4, 32'h0);
    check("fill byte0", {24'h0, iord[7:0]}, 32'h21);
    io_op(4'h4, 32'h0);
    check("hit byte1", {24'h0, iord[7:0]}, 32'h43);
    check("hit no memory", mem_model_inst.last.addr, 32'h000000BC);
    buffered_mode = 1'b0;
    $display("test buffer done");
    final_report();
  end
endmodule
